/* logic/ssa_safety_stop_arbiter.sv */
// Stop arbitration and alarm handling of the drive safety monitor.
// Assumes raw active-low command pins and active-high input devices, speed observation results
// from elsewhere on the same clock, and an APB master for configuration and alarms.
`timescale 1ns/1ns

// Functional notes
// - Any active trigger starts and holds function.
// - One SS1 timer, started by earliest trigger.
// - SS1 continues on SS1 stop alarm after command withdrawn.
// - SS1 request during STO does nothing.
// - STO release keeps SS1 caused torque off.
// - STO request aborts SS1, enters STO.
// - STO brake stop uses STO plus brake.
// - SS1 electronic brake stop by rating.
// - SS1 forced decel stop decelerates.
// - Dynamic brake stop, coast without brake.
// - Alarm torque off latched until reset.
// - Serious error stops SLS and SSM.
// - Stopped observation drives outputs off.
// - Alarm clears only after cause removed.
// - Input mode reset needs enabled inputs on.
// - Unassigned input pins ignored by reset.
// - Controller reset needs all commands on.
// - Status output for each safety function.
module ssa_safety_stop_arbiter
    import ssa_pkg::*;
(
    input wire logic sys_clk, // System clock, 25 MHz.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic [7:0] paddr, // APB address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire ssa_cmd_t cmdPins, // Active-low commands from the controller.
    input wire logic [5:0] inputDevice, // Input device pins, high when on.
    input wire logic slsSpeedOk, // SLS observation reports speed in limit.
    input wire logic ssmSpeedOk, // SSM observation reports speed in range.
    input wire logic standstill, // Motor has reached standstill.
    output ssa_monitor_t stateMonitor, // Function status signals.
    output ssa_brake_t brakeCmd, // Stop action toward the power stage.
    output logic torqueEnable, // Power stage may produce torque.
    output logic malfunction_flag, // High with no alarm, low on alarm.
    output logic torque_off_output, // Low while torque is shut off.
    output logic [5:0] outputDevice // Output devices, forced off on serious error.
);

    ssa_cmd_t cmdS1, cmdS2, cmdS3;
    logic [5:0] devS1, devS2, devS3;
    ssa_cmd_t cmd;
    logic [5:0] dev;
    logic [31:0] ctrl;
    logic [31:0] ss1TimeCyc;
    logic [31:0] ss1Count;
    ssa_stop_t alarmMethod;
    logic alarmActive, alarmSerious, alarmCause;
    ssa_state_t state, next_state;
    logic stoLatched;
    logic resetReq;
    logic apbWrite, apbAccess;

    // Three-stage synchronisers; a change is taken once stages two and three agree.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cmdS1 <= '1;
            cmdS2 <= '1;
            cmdS3 <= '1;
            devS1 <= 6'h00;
            devS2 <= 6'h00;
            devS3 <= 6'h00;
        end else begin
            cmdS1 <= cmdPins;
            cmdS2 <= cmdS1;
            cmdS3 <= cmdS2;
            devS1 <= inputDevice;
            devS2 <= devS1;
            devS3 <= devS2;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cmd <= '1;
            dev <= 6'h00;
        end else begin
            for (int i = 0; i < $bits(cmd); i++) begin
                if (cmdS2[i] == cmdS3[i]) begin
                    cmd[i] <= cmdS3[i];
                end
            end
            for (int i = 0; i < 6; i++) begin
                if (devS2[i] == devS3[i]) begin
                    dev[i] <= devS3[i];
                end
            end
        end
    end

    // Requests are active low, so a low command means the function is wanted.
    logic stoWanted, ss1Cmd, ss1ByAlarm, ss1Wanted, stoByAlarm;
    logic [5:0] enabledInputs;
    logic allOn;
    assign stoWanted = !cmd.stoRequest || stoByAlarm;
    assign ss1Cmd = !cmd.ss1Request;
    assign ss1ByAlarm = alarmActive &&
        (alarmMethod == STOP_SS1_ELEC || alarmMethod == STOP_SS1_DECEL);
    assign stoByAlarm = alarmActive && alarmMethod == STOP_STO_DYN;
    assign ss1Wanted = ss1Cmd || ss1ByAlarm;
    assign enabledInputs = ctrl[CTRL_ENA_LSB +: 6];
    // Unassigned pins are masked out of the reset check.
    assign allOn = ctrl[CTRL_MODE_BIT] ? (&cmd)
        : ((dev & enabledInputs) == enabledInputs);

    // APB slave, zero wait states.
    assign apbAccess = psel && penable;
    assign apbWrite = apbAccess && pwrite;
    assign resetReq = apbWrite && paddr == REG_ALARM && pstrb[0] && pwdata[FAULT_RESET_BIT];

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl <= CTRL_RST;
            ss1TimeCyc <= SS1_TIME_CYC_DEF;
        end else if (apbWrite) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b] && paddr == REG_CTRL) begin
                    ctrl[b*8 +: 8] <= pwdata[b*8 +: 8];
                end
                if (pstrb[b] && paddr == REG_SS1TIME) begin
                    ss1TimeCyc[b*8 +: 8] <= pwdata[b*8 +: 8];
                end
            end
        end
    end

    // Alarm record: raised by software writes to the alarm register, cleared by an alarm reset.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            alarmActive <= 1'b0;
            alarmSerious <= 1'b0;
            alarmCause <= 1'b0;
            alarmMethod <= STOP_NONE;
        end else if (apbWrite && paddr == REG_ALARM && pstrb[0] && pwdata[FAULT_RAISE_BIT]) begin
            // Raising wins over a reset in the same write.
            alarmActive <= 1'b1;
            alarmCause <= 1'b1;
            alarmSerious <= pwdata[FAULT_SERIOUS_BIT];
            alarmMethod <= ssa_stop_t'(pwdata[FAULT_METHOD_LSB +: 3]);
        end else if (apbWrite && paddr == REG_ALARM && pstrb[0] && !pwdata[FAULT_RAISE_BIT]
                && !resetReq) begin
            alarmCause <= 1'b0;
        end else if (resetReq && !alarmCause && allOn) begin
            // The cause must already be cleared before a reset is honoured.
            alarmActive <= 1'b0;
            alarmSerious <= 1'b0;
            alarmMethod <= STOP_NONE;
        end
    end

    // Torque off in STO while an alarm or an SS1 command is present, as after a finished SS1, stays latched.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stoLatched <= 1'b0;
        end else if (state == ST_STO && (alarmActive || ss1Cmd)) begin
            stoLatched <= 1'b1;
        end else if (!alarmActive && !ss1Cmd && !stoWanted && (resetReq ? allOn : !alarmCause)) begin
            stoLatched <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (stoWanted) begin
                    next_state = ST_STO;
                end else if (ss1Wanted) begin
                    next_state = ST_SS1;
                end else if (alarmActive) begin
                    next_state = ST_DRIVE_STOP;
                end
            end
            ST_SS1: begin
                if (stoWanted) begin
                    next_state = ST_STO;
                end else if (ss1Count == 32'h0 || standstill) begin
                    next_state = ST_STO;
                end else if (!ss1Wanted) begin
                    next_state = ST_RUN;
                end
            end
            ST_STO: begin
                // An SS1 request arriving here neither decelerates nor counts.
                if (!stoWanted && !ss1Wanted && !stoLatched && !alarmActive) begin
                    next_state = ST_RUN;
                end
            end
            ST_DRIVE_STOP: begin
                if (stoWanted || ss1Wanted) begin
                    next_state = ST_STO;
                end else if (!alarmActive) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_STO;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // One timer, loaded only when SS1 is entered, so later triggers do not restart it.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ss1Count <= 32'h0;
        end else if (state != ST_SS1 && next_state == ST_SS1) begin
            ss1Count <= ss1TimeCyc;
        end else if (state == ST_SS1 && ss1Count != 32'h0) begin
            ss1Count <= ss1Count - 32'h1;
        end
    end

    // Outputs, all registered.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            torqueEnable <= 1'b0;
            torque_off_output <= 1'b0;
            malfunction_flag <= 1'b1;
            brakeCmd <= '0;
            stateMonitor <= '0;
            outputDevice <= 6'h00;
        end else begin
            torqueEnable <= next_state == ST_RUN || next_state == ST_SS1;
            torque_off_output <= next_state == ST_RUN || next_state == ST_SS1;
            malfunction_flag <= !alarmActive;
            brakeCmd.forcedDecel <= next_state == ST_SS1 &&
                (ss1Cmd || alarmMethod == STOP_SS1_DECEL) ||
                (next_state == ST_DRIVE_STOP && alarmMethod == STOP_DECEL);
            brakeCmd.electronicBrake <= !ctrl[CTRL_BIGAMP_BIT] && next_state != ST_RUN &&
                !(next_state == ST_SS1 && ss1Cmd) && (alarmMethod == STOP_SS1_ELEC ||
                alarmMethod == STOP_ELEC);
            brakeCmd.dynamicBrake <= ctrl[CTRL_HASDB_BIT] && (next_state == ST_STO ||
                (next_state == ST_DRIVE_STOP && (alarmMethod == STOP_DYN ||
                (alarmMethod == STOP_ELEC && ctrl[CTRL_BIGAMP_BIT]))));
            brakeCmd.coast <= !ctrl[CTRL_HASDB_BIT] && (next_state == ST_STO ||
                next_state == ST_DRIVE_STOP);
            stateMonitor.sto <= next_state == ST_STO;
            stateMonitor.ss1 <= next_state == ST_SS1;
            stateMonitor.ss2 <= !cmd.ss2Request;
            stateMonitor.sos <= !cmd.ss2Request && standstill;
            stateMonitor.sbc <= next_state == ST_STO;
            // A serious error stops SLS and SSM observation and forces outputs off.
            stateMonitor.sls <= !alarmSerious && !(&cmd.speedLimitRequest) && slsSpeedOk;
            stateMonitor.ssm <= !alarmSerious && ssmSpeedOk;
            outputDevice <= alarmSerious ? 6'h00 : {ssmSpeedOk, slsSpeedOk,
                next_state == ST_STO, next_state == ST_SS1, standstill,
                !cmd.ss2Request};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != REG_CTRL && paddr != REG_SS1TIME &&
                paddr != REG_ALARM && paddr != REG_STATUS && paddr != REG_INPUTS;
            unique case (paddr)
                REG_CTRL: prdata <= ctrl;
                REG_SS1TIME: prdata <= ss1TimeCyc;
                REG_ALARM: prdata <= {26'h0, 1'b0, alarmCause, alarmSerious, alarmMethod};
                REG_STATUS: prdata <= {20'h0, state, 1'b0, stateMonitor};
                REG_INPUTS: prdata <= {19'h0, cmd, dev};
                default: prdata <= 32'h0;
            endcase
        end
    end

endmodule

/* shared/ssa_pkg.sv */
// Constants, register map and carrier types of the safety stop arbiter.
// Assumes a 25 MHz system clock and an APB register port with 32-bit data.
package ssa_pkg;

    localparam int unsigned SYS_CLK_HZ = 25000000;

    // The SS1 monitoring deceleration time defaults to 1000 ms.
    localparam int unsigned SS1_TIME_MS_DEF = 1000;
    localparam int unsigned CYC_PER_MS = SYS_CLK_HZ / 1000;
    localparam logic [31:0] SS1_TIME_CYC_DEF = 32'(SS1_TIME_MS_DEF * CYC_PER_MS);

    // Register byte addresses.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SS1TIME = 8'h04;
    localparam logic [7:0] REG_ALARM = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_INPUTS = 8'h10;

    // Control register fields.
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_BIGAMP_BIT = 1;
    localparam int CTRL_HASDB_BIT = 2;
    localparam int CTRL_ENA_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0004;

    // Alarm register fields: stop method in [2:0], serious flag, cause still present.
    localparam int FAULT_METHOD_LSB = 0;
    localparam int FAULT_SERIOUS_BIT = 3;
    localparam int FAULT_RAISE_BIT = 4;
    localparam int FAULT_RESET_BIT = 5;

    // Stop methods on an internal alarm.
    typedef enum logic [2:0] {
        STOP_NONE = 3'h0,
        STOP_DYN = 3'h1,
        STOP_ELEC = 3'h2,
        STOP_DECEL = 3'h3,
        STOP_STO_DYN = 3'h4,
        STOP_SS1_ELEC = 3'h5,
        STOP_SS1_DECEL = 3'h6
    } ssa_stop_t;

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_SS1 = 4'b0010,
        ST_STO = 4'b0100,
        ST_DRIVE_STOP = 4'b1000
    } ssa_state_t;

    // Active-low safety commands: low means the function is requested.
    typedef struct packed {
        logic stoRequest;
        logic ss1Request;
        logic ss2Request;
        logic [3:0] speedLimitRequest;
    } ssa_cmd_t;

    // Function state outputs, high while the function is active.
    typedef struct packed {
        logic ssm;
        logic sbc;
        logic sto;
        logic sos;
        logic ss1;
        logic ss2;
        logic sls;
    } ssa_monitor_t;

    // Stop actions toward the power stage.
    typedef struct packed {
        logic dynamicBrake;
        logic electronicBrake;
        logic forcedDecel;
        logic coast;
    } ssa_brake_t;

endpackage

/* dv/ssa_arb_chk.sv */
// Port checker for the safety stop arbiter.
// Assumes it is bound to the arbiter and sees only its ports, on one clock.
`timescale 1ns/1ns
module ssa_arb_chk
    import ssa_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic [7:0] paddr, // APB address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [31:0] pwdata, // APB write data.
    input wire ssa_cmd_t cmdPins, // Active-low commands.
    input wire ssa_monitor_t stateMonitor, // Function status.
    input wire logic torqueEnable, // Torque allowed.
    input wire logic malfunction_flag, // Low on alarm.
    input wire logic torque_off_output, // Low while torque is off.
    input wire logic [5:0] outputDevice // Output devices.
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    wire faultWr = psel && penable && pwrite && paddr == REG_ALARM;
    wire raiseWr = faultWr && pwdata[FAULT_RAISE_BIT];
    wire resetWr = faultWr && pwdata[FAULT_RESET_BIT] && !pwdata[FAULT_RAISE_BIT];
    // Eight cycles covers the synchroniser, the filter and the output register.
    property p_sto_cmd;
        !cmdPins.stoRequest [*8] |-> !torque_off_output && stateMonitor.sto && !stateMonitor.ss1;
    endproperty
    a_sto_cmd: assert property (p_sto_cmd)
        else $error("STO command did not shut torque off");
    property p_no_ss1;
        !torque_off_output && stateMonitor.sto |=> !$rose(stateMonitor.ss1);
    endproperty
    a_no_ss1: assert property (p_no_ss1)
        else $error("SS1 started while STO was in effect");
    property p_latch;
        $rose(malfunction_flag) |-> $past(resetWr) || $past(resetWr, 2) || $past(resetWr, 3);
    endproperty
    a_latch: assert property (p_latch)
        else $error("Alarm cleared without an alarm reset");
    property p_raise;
        raiseWr |-> ##[1:3] !malfunction_flag;
    endproperty
    a_raise: assert property (p_raise)
        else $error("Alarm flag did not fall on an alarm");
    property p_serious;
        raiseWr && pwdata[3] |-> ##[1:3] (outputDevice == 6'h00 && !stateMonitor.sls
            && !stateMonitor.ssm);
    endproperty
    a_serious: assert property (p_serious)
        else $error("Serious alarm left observation or outputs on");
    property p_tq_en;
        torqueEnable |-> torque_off_output;
    endproperty
    a_tq_en: assert property (p_tq_en)
        else $error("Torque enabled while torque output shows off");
    property p_sto_out;
        stateMonitor.sto |-> !torque_off_output;
    endproperty
    a_sto_out: assert property (p_sto_out)
        else $error("STO status high with torque output on");
    property p_ss1_hold;
        $fell(stateMonitor.ss1) && !malfunction_flag |-> !torque_off_output;
    endproperty
    a_ss1_hold: assert property (p_ss1_hold)
        else $error("SS1 dropped during an alarm without torque off");
    c_ss1: cover property ($rose(stateMonitor.ss1));
    c_clear: cover property ($rose(malfunction_flag));
    c_serious: cover property (raiseWr && pwdata[3]);
endmodule

bind ssa_safety_stop_arbiter ssa_arb_chk u_chk (.sys_clk, .reset_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .cmdPins, .stateMonitor, .torqueEnable, .malfunction_flag,
    .torque_off_output, .outputDevice);

/* dv/ssa_cmd_model.sv */
// Behavioural model of the controller that drives the command and input device pins.
// Assumes the bench calls drive with the next levels it wants on the pins.
`timescale 1ns/1ns
module ssa_cmd_model
    import ssa_pkg::*;
(
    input wire logic sys_clk, // System clock.
    output ssa_cmd_t cmdPins, // Active-low safety commands.
    output logic [5:0] inputDevice // Input devices, high when on.
);
    // Commands start inactive, which is the high level.
    initial begin
        cmdPins = '1;
        inputDevice = 6'h3f;
    end
    // Levels change just after an edge and then hold; before some alarm resets the bench
    // leaves an enabled input or a command low, to check that the reset is refused.
    task automatic drive(input ssa_cmd_t c, input logic [5:0] d);
        @(posedge sys_clk);
        cmdPins <= c;
        inputDevice <= d;
    endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the safety stop arbiter.
// Assumes the checker is bound in and the command model drives the safety pins.
`timescale 1ns/1ns
module tb
    import ssa_pkg::*;
;
    logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic slsSpeedOk = 1, ssmSpeedOk = 1, standstill = 0, err;
    logic torqueEnable, malfunction_flag, torque_off_output;
    logic [5:0] inputDevice, outputDevice;
    ssa_cmd_t cmdPins;
    ssa_monitor_t stateMonitor;
    ssa_brake_t brakeCmd;
    int errors = 0, check_count = 0, now = 0, t0;
    // Rows: control value, alarm method, expected brake, flags (4 SS1 row, 2 torque off).
    localparam logic [15:0] ROWS [8] = '{16'h4180, 16'h4240, 16'h6280, 16'h0110,
        16'h4320, 16'h4482, 16'h4504, 16'h4604};
    ssa_safety_stop_arbiter dut (.sys_clk, .reset_n, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .cmdPins, .inputDevice, .slsSpeedOk,
        .ssmSpeedOk, .standstill, .stateMonitor, .brakeCmd, .torqueEnable,
        .malfunction_flag, .torque_off_output, .outputDevice);
    ssa_cmd_model cm (.sys_clk, .cmdPins, .inputDevice);
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) now <= now + 1;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic cmd(input logic [2:0] c, input logic [5:0] d = 6'h3f);
        cm.drive({c, 4'hf}, d);
    endtask
    function automatic logic pick(input int s);
        return s == 1 ? stateMonitor.ss1 : torque_off_output;
    endfunction
    task automatic waitFor(input string nm, input int s, input logic v);
        int n;
        n = 0;
        while (pick(s) !== v && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        chk(nm, v, pick(s));
    endtask
    // Clear the cause first, then reset, as an alarm only clears once its cause is gone.
    task automatic clrAlm;
        wr(REG_ALARM, 32'h0);
        wr(REG_ALARM, 32'h20);
        cyc(4);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        errors++;
        results;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1;
        chk("alarm_flag", 1, malfunction_flag);
        apb(0, REG_CTRL, 0);
        chk("ctrl", CTRL_RST, rd);
        apb(0, REG_SS1TIME, 0);
        chk("ss1time", SS1_TIME_CYC_DEF, rd);
        apb(0, 8'h14, 0);
        chk("slverr", 1, err);
        $display("test reset done");
        cmd(3'b011);
        waitFor("torque_off", 0, 0);
        apb(0, REG_STATUS, 0);
        chk("state", ST_STO, rd[11:8]);
        chk("sto_status", 1, rd[4]);
        cmd(3'b001);
        cyc(8);
        chk("ss1", 0, stateMonitor.ss1);
        cmd(3'b101);
        cyc(8);
        chk("torque_off", 0, torque_off_output);
        cmd(3'b111);
        waitFor("torque_off", 0, 1);
        $display("test sto done");
        wr(REG_SS1TIME, 32'h14);
        cmd(3'b101);
        waitFor("ss1", 1, 1);
        t0 = now;
        cyc(3);
        wr(REG_ALARM, 32'h16);
        cmd(3'b111);
        cyc(8);
        chk("ss1", 1, stateMonitor.ss1);
        waitFor("torque_off", 0, 0);
        chk("ss1_time", 1, (now - t0) inside {[18:24]});
        wr(REG_ALARM, 32'h20);
        cyc(4);
        chk("alarm_flag", 0, malfunction_flag);
        clrAlm;
        chk("alarm_flag", 1, malfunction_flag);
        waitFor("torque_off", 0, 1);
        wr(REG_SS1TIME, 32'd1000);
        cmd(3'b101);
        waitFor("ss1", 1, 1);
        cmd(3'b001);
        waitFor("torque_off", 0, 0);
        chk("ss1", 0, stateMonitor.ss1);
        cmd(3'b111);
        waitFor("torque_off", 0, 1);
        $display("test ss1 done");
        foreach (ROWS[i]) begin
            wr(REG_CTRL, 32'(ROWS[i][15:12]));
            wr(REG_ALARM, 32'h10 | 32'(ROWS[i][11:8]));
            cyc(4);
            chk("alarm_flag", 0, malfunction_flag);
            if (ROWS[i][2])
                chk("ss1", 1, stateMonitor.ss1);
            else
                chk("brake", ROWS[i][7:4], brakeCmd);
            if (ROWS[i][1])
                chk("torque_off", 0, torque_off_output);
            clrAlm;
            chk("alarm_flag", 1, malfunction_flag);
        end
        cm.drive(7'h7e, 6'h3f);
        cyc(8);
        chk("sls", 1, stateMonitor.sls);
        wr(REG_ALARM, 32'h19);
        cyc(4);
        chk("out_dev", 0, outputDevice);
        chk("sls_ssm", 0, {stateMonitor.sls, stateMonitor.ssm});
        clrAlm;
        cmd(3'b111);
        $display("test methods done");
        wr(REG_CTRL, 32'h304);
        wr(REG_ALARM, 32'h14);
        wr(REG_ALARM, 32'h0);
        cmd(3'b111, 6'h3d);
        cyc(6);
        wr(REG_ALARM, 32'h20);
        cyc(4);
        chk("alarm_flag", 0, malfunction_flag);
        cmd(3'b111, 6'h03);
        cyc(6);
        wr(REG_ALARM, 32'h20);
        cyc(4);
        chk("alarm_flag", 1, malfunction_flag);
        wr(REG_CTRL, 32'h5);
        wr(REG_ALARM, 32'h14);
        wr(REG_ALARM, 32'h0);
        cmd(3'b110);
        cyc(6);
        chk("ss2", 1, stateMonitor.ss2);
        wr(REG_ALARM, 32'h20);
        cyc(4);
        chk("alarm_flag", 0, malfunction_flag);
        cmd(3'b111);
        cyc(6);
        wr(REG_ALARM, 32'h20);
        cyc(4);
        chk("alarm_flag", 1, malfunction_flag);
        waitFor("torque_off", 0, 1);
        $display("test alarm reset done");
        results;
    end
endmodule
